// [pdm_cmd_dec.sv]
// Target command decoder: which PCI commands the device claims and how
`timescale 1ns/1ps
module pdm_cmd_dec (
   input  wire logic [3:0]       cmd,
   input  wire logic             bar_mem,
   input  wire logic             bar_io,
   input  wire logic [1:0]       addr_lo,
   output      pdm_pkg::pdm_dec_t dec
);
   always_comb begin
      dec = '0;
      unique case (cmd)
         pdm_pkg::CMD_IO_RD: begin
            dec.claim   = bar_io;
            dec.is_read = 1'b1;
         end
         pdm_pkg::CMD_IO_WR: begin
            dec.claim    = bar_io;
            dec.is_write = 1'b1;
         end
         // Read aliases fold onto memory read; linear burst only
         pdm_pkg::CMD_MEM_RD, pdm_pkg::CMD_MRM, pdm_pkg::CMD_MRL: begin // [RQ21] [RQ22]
            dec.claim   = bar_mem && (addr_lo == 2'h0);
            dec.is_read = 1'b1;
         end
         pdm_pkg::CMD_MEM_WR, pdm_pkg::CMD_MWI: begin // [RQ21] [RQ22]
            dec.claim    = bar_mem && (addr_lo == 2'h0);
            dec.is_write = 1'b1;
         end
         pdm_pkg::CMD_CFG_RD: begin // [RQ20]
            dec.claim   = 1'b1;
            dec.is_read = 1'b1;
            dec.is_cfg  = 1'b1;
         end
         pdm_pkg::CMD_CFG_WR: begin // [RQ20]
            dec.claim    = 1'b1;
            dec.is_write = 1'b1;
            dec.is_cfg   = 1'b1;
         end
         // Unsupported and reserved codes
         default: dec = '0; // [RQ20]
      endcase
   end
endmodule

// [pdm_dma.sv]
// Two-channel PCI DMA engine with codec access
// Overview of operation
// RQ1: Two independent DMA channels.
// RQ2: Dword-aligned start and end addresses.
// RQ3: Addresses and preload before start.
// RQ4: Enable bit 8 starts and stops.
// RQ5: Restart bit 9 only in single mode.
// RQ6: Current address at 0x14 and 0x24.
// RQ7: Interrupt address hit sets flag.
// RQ8: Status bits interrupt only when unmasked; abort bits 5:4 bypass the 4-bit mask here.
// RQ9: Aborts recorded in bits 5:4.
// RQ10: Status read clears it.
// RQ11: Clear reset, set enable to recover.
// RQ12: Level mode: status follows condition.
// RQ13: Edge mode: status latches until written one.
// RQ14: Multiple mode wraps to start.
// RQ15: Single mode halts at end.
// RQ16: Bits 12:11 select direct or indirect.
// RQ17: Memory and I/O windows alike.
// RQ18: Flagged write words program codec.
// RQ19: Indirect samples carry 15 bits.
// RQ20: Refuse special commands; accept I/O, config.
// RQ21: Linear burst memory read/write only.
// RQ22: Aliases act as base commands.
// RQ23: FIFOs: eight 16-bit samples, unmapped.
// RQ24: DMA sources drive level interrupt.
// RQ25: Address steps four, reloads start.
// RQ26: Bus requested only with data or space.
`timescale 1ns/1ps
module pdm_dma (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // Target side
   input  wire pdm_pkg::pdm_tgt_req_t tgt_req,
   output      pdm_pkg::pdm_tgt_rsp_t tgt_rsp,
   // Bus-master side
   output      pdm_pkg::pdm_mst_req_t mst_req,
   input  wire logic                 mst_ack,
   input  wire logic [31:0]          mst_rdata,
   input  wire logic                 mst_mabort,
   input  wire logic                 mst_tabort,
   // Receive samples
   input  wire logic                 rx_valid,
   output      logic                 rx_ready,
   input  wire logic [15:0]          rx_data,
   // Transmit samples
   output      logic                 tx_valid,
   input  wire logic                 tx_ready,
   output      logic [15:0]          tx_data,
   // Codec port and interrupt
   output      pdm_pkg::pdm_codec_t   codec,
   input  wire logic [7:0]           codec_rdata,
   output      logic                 irq
);
   typedef struct packed {
      logic [31:0]             ctrl;
      logic [5:0]              status;
      logic [3:0]              mask;
      logic [31:0]             rd_start;
      logic [31:0]             rd_end;
      logic [31:0]             rd_irq;
      logic [31:0]             rd_cur;
      logic [31:0]             wr_start;
      logic [31:0]             wr_end;
      logic [31:0]             wr_irq;
      logic [31:0]             wr_cur;
      logic                    rd_done;
      logic                    wr_done;
      logic                    prev_en;
      logic                    last_wr;
      pdm_pkg::pdm_mst_state_t mst;
      pdm_pkg::pdm_mst_req_t   mreq;
      pdm_pkg::pdm_tgt_rsp_t   rsp;
      pdm_pkg::pdm_codec_t     codec;
      logic                    tx_valid;
      logic [15:0]             tx_data;
      logic                    rx_ready;
      logic                    irq;
   } pdm_state_t;

   pdm_state_t        s_r;
   pdm_state_t        s_nxt;
   pdm_pkg::pdm_dec_t dec;
   logic              rdf_valid;
   logic [15:0]       rdf_data;
   logic              rdf_pop;
   logic              rdf_in_ready;
   logic              wrf_in_ready;
   logic              wrf_push;
   logic              wrf_valid;
   logic [15:0]       wrf_data;
   logic              wrf_pop;

   pdm_cmd_dec u_dec (
      .cmd     (tgt_req.cmd),
      .bar_mem (tgt_req.bar_mem),
      .bar_io  (tgt_req.bar_io),
      .addr_lo (tgt_req.addr[1:0]),
      .dec     (dec)
   );

   // Read channel FIFO
   pdm_fifo #(.WIDTH(pdm_pkg::SAMPLE_W), .DEPTH(pdm_pkg::FIFO_DEPTH)) u_rd_fifo ( // [RQ23]
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (rx_valid),
      .in_ready  (rdf_in_ready),
      .in_data   (rx_data),
      .out_valid (rdf_valid),
      .out_ready (rdf_pop),
      .out_data  (rdf_data)
   );

   // Write channel FIFO
   pdm_fifo #(.WIDTH(pdm_pkg::SAMPLE_W), .DEPTH(pdm_pkg::FIFO_DEPTH)) u_wr_fifo ( // [RQ23]
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (wrf_push),
      .in_ready  (wrf_in_ready),
      .in_data   (mst_rdata[15:0]),
      .out_valid (wrf_valid),
      .out_ready (wrf_pop),
      .out_data  (wrf_data)
   );

   assign tgt_rsp  = s_r.rsp;
   assign mst_req  = s_r.mreq;
   assign codec    = s_r.codec;
   assign tx_valid = s_r.tx_valid;
   assign tx_data  = s_r.tx_data;
   assign rx_ready = s_r.rx_ready;
   assign irq      = s_r.irq;

   // Space was checked at issue
   assign wrf_push = (s_r.mst == pdm_pkg::MS_BUSY) && mst_ack && s_r.mreq.write == 1'b0; // [RQ26]
   // Refill when empty or draining
   assign wrf_pop  = !s_r.tx_valid || tx_ready;

   function automatic logic [31:0] reg_read(input pdm_state_t st, input logic [11:0] a, input logic [7:0] crd);
      logic [31:0] v;
      v = 32'h0;
      if (a[pdm_pkg::CODEC_SEL_BIT]) begin
         v = {24'h0, crd};
      end else begin
         unique case (a)
            pdm_pkg::OFF_CTRL:     v = st.ctrl;
            pdm_pkg::OFF_STATUS:   v = {26'h0, st.status};
            pdm_pkg::OFF_RD_START: v = st.rd_start;
            pdm_pkg::OFF_RD_END:   v = st.rd_end;
            pdm_pkg::OFF_RD_IRQ:   v = st.rd_irq;
            pdm_pkg::OFF_RD_CUR:   v = st.rd_cur; // [RQ6]
            pdm_pkg::OFF_WR_START: v = st.wr_start;
            pdm_pkg::OFF_WR_END:   v = st.wr_end;
            pdm_pkg::OFF_WR_IRQ:   v = st.wr_irq;
            pdm_pkg::OFF_WR_CUR:   v = st.wr_cur; // [RQ6]
            pdm_pkg::OFF_MASK:     v = {28'h0, st.mask};
            default:               v = 32'h0;
         endcase
      end
      return v;
   endfunction

   always_comb begin
      logic        acc_rd;
      logic        acc_wr;
      logic        indirect;
      logic        edge_mode;
      logic        multi;
      logic        reload;
      logic [5:0]  evt;
      logic [5:0]  lvl;
      logic [5:0]  clr;
      logic [31:0] nxt_addr;
      logic        rd_go;
      logic        wr_go;
      s_nxt     = s_r;
      acc_rd    = tgt_req.valid && dec.claim && dec.is_read && !dec.is_cfg;
      acc_wr    = tgt_req.valid && dec.claim && dec.is_write && !dec.is_cfg;
      indirect  = (s_r.ctrl[pdm_pkg::CTL_DM_HI:pdm_pkg::CTL_DM_LO] == pdm_pkg::DM_INDIRECT); // [RQ16]
      edge_mode = s_r.ctrl[pdm_pkg::CTL_IRQ_EDGE];
      multi     = s_r.ctrl[pdm_pkg::CTL_MULTI];
      reload    = 1'b0;
      evt       = 6'h0;
      clr       = 6'h0;
      nxt_addr  = 32'h0;
      rd_go     = 1'b0;
      wr_go     = 1'b0;
      rdf_pop   = 1'b0;
      lvl = 6'h0;
      lvl[pdm_pkg::ST_RD_EOB] = s_r.rd_done;
      lvl[pdm_pkg::ST_WR_EOB] = s_r.wr_done;
      lvl[pdm_pkg::ST_RD_IA]  = (s_r.rd_irq != 32'h0) && (s_r.rd_cur == s_r.rd_irq);
      lvl[pdm_pkg::ST_WR_IA]  = (s_r.wr_irq != 32'h0) && (s_r.wr_cur == s_r.wr_irq);
      s_nxt.codec.wr = 1'b0;

      // Answer every request next cycle
      s_nxt.rsp.done  = tgt_req.valid;
      s_nxt.rsp.claim = tgt_req.valid && dec.claim; // [RQ20]
      s_nxt.rsp.rdata = acc_rd ? reg_read(s_r, tgt_req.addr, codec_rdata) : 32'h0; // [RQ17]
      if (acc_rd && tgt_req.addr == pdm_pkg::OFF_STATUS) begin
         clr = 6'h3f; // [RQ10]
      end

      // Both windows share one map
      if (acc_wr && tgt_req.addr[pdm_pkg::CODEC_SEL_BIT]) begin // [RQ17]
         if (!indirect) begin // [RQ16]
            s_nxt.codec.wr   = 1'b1;
            s_nxt.codec.addr = tgt_req.addr[9:2];
            s_nxt.codec.data = tgt_req.wdata[7:0];
         end
      end else if (acc_wr) begin
         unique case (tgt_req.addr)
            pdm_pkg::OFF_CTRL: begin
               s_nxt.ctrl = tgt_req.wdata & pdm_pkg::CTRL_WR_MASK;
               // Restart is an action, never stored
               if (tgt_req.wdata[pdm_pkg::CTL_RESTART] && !multi) begin // [RQ5]
                  reload = 1'b1;
               end
            end
            pdm_pkg::OFF_STATUS:   clr = tgt_req.wdata[5:0]; // [RQ13]
            pdm_pkg::OFF_RD_START: s_nxt.rd_start = tgt_req.wdata;
            pdm_pkg::OFF_RD_END:   s_nxt.rd_end   = tgt_req.wdata;
            pdm_pkg::OFF_RD_IRQ:   s_nxt.rd_irq   = tgt_req.wdata;
            pdm_pkg::OFF_WR_START: s_nxt.wr_start = tgt_req.wdata;
            pdm_pkg::OFF_WR_END:   s_nxt.wr_end   = tgt_req.wdata;
            pdm_pkg::OFF_WR_IRQ:   s_nxt.wr_irq   = tgt_req.wdata;
            pdm_pkg::OFF_MASK:     s_nxt.mask     = tgt_req.wdata[3:0];
            default: ;
         endcase
      end

      // New enable or reset bit rewinds
      s_nxt.prev_en = s_r.ctrl[pdm_pkg::CTL_EN];
      if ((s_r.ctrl[pdm_pkg::CTL_EN] && !s_r.prev_en) || s_r.ctrl[pdm_pkg::CTL_RST]) begin // [RQ25]
         reload = 1'b1;
      end

      // Bus-master state machine
      unique case (s_r.mst)
         pdm_pkg::MS_IDLE: begin
            if (s_r.ctrl[pdm_pkg::CTL_EN] && !s_r.ctrl[pdm_pkg::CTL_RST] && !reload) begin // [RQ4]
               rd_go = !s_r.rd_done && rdf_valid && (s_r.rd_cur != s_r.rd_end); // [RQ26]
               wr_go = !s_r.wr_done && wrf_in_ready && (s_r.wr_cur != s_r.wr_end); // [RQ26]
               // Alternate so neither starves
               if (rd_go && wr_go) begin // [RQ1]
                  rd_go = s_r.last_wr;
                  wr_go = !s_r.last_wr;
               end
            end
            if (rd_go) begin
               rdf_pop = 1'b1;
               s_nxt.mreq = '{req: 1'b1, write: 1'b1, addr: s_r.rd_cur, wdata: {16'h0, rdf_data}};
               s_nxt.last_wr = 1'b0;
               s_nxt.mst = pdm_pkg::MS_BUSY;
            end else if (wr_go) begin
               s_nxt.mreq = '{req: 1'b1, write: 1'b0, addr: s_r.wr_cur, wdata: 32'h0};
               s_nxt.last_wr = 1'b1;
               s_nxt.mst = pdm_pkg::MS_BUSY;
            end
         end
         pdm_pkg::MS_BUSY: begin
            if (mst_mabort || mst_tabort) begin
               evt[pdm_pkg::ST_MABORT] = mst_mabort; // [RQ9]
               evt[pdm_pkg::ST_TABORT] = mst_tabort; // [RQ9]
               s_nxt.mreq.req = 1'b0;
               s_nxt.ctrl[pdm_pkg::CTL_EN] = 1'b0;
               s_nxt.mst = pdm_pkg::MS_HALT;
            end else if (mst_ack) begin
               s_nxt.mreq.req = 1'b0;
               s_nxt.mst = pdm_pkg::MS_IDLE;
               if (s_r.mreq.write) begin
                  nxt_addr = s_r.rd_cur + pdm_pkg::DWORD_STEP; // [RQ25]
                  evt[pdm_pkg::ST_RD_IA] = lvl[pdm_pkg::ST_RD_IA]; // [RQ7]
                  if (nxt_addr == s_r.rd_end) begin
                     evt[pdm_pkg::ST_RD_EOB] = 1'b1;
                     s_nxt.rd_cur  = multi ? s_r.rd_start : nxt_addr; // [RQ14]
                     s_nxt.rd_done = !multi; // [RQ15]
                  end else begin
                     s_nxt.rd_cur = nxt_addr;
                  end
               end else begin
                  nxt_addr = s_r.wr_cur + pdm_pkg::DWORD_STEP; // [RQ25]
                  evt[pdm_pkg::ST_WR_IA] = lvl[pdm_pkg::ST_WR_IA]; // [RQ7]
                  if (nxt_addr == s_r.wr_end) begin
                     evt[pdm_pkg::ST_WR_EOB] = 1'b1;
                     s_nxt.wr_cur  = multi ? s_r.wr_start : nxt_addr; // [RQ14]
                     s_nxt.wr_done = !multi; // [RQ15]
                  end else begin
                     s_nxt.wr_cur = nxt_addr;
                  end
               end
            end
         end
         pdm_pkg::MS_HALT: begin
            // Wait for reset clear, enable set
            if (!s_r.ctrl[pdm_pkg::CTL_RST] && s_r.ctrl[pdm_pkg::CTL_EN]) begin // [RQ11]
               s_nxt.mst = pdm_pkg::MS_IDLE;
            end
         end
         default: s_nxt.mst = pdm_pkg::MS_IDLE;
      endcase

      if (reload) begin
         s_nxt.rd_cur  = s_r.rd_start; // [RQ25]
         s_nxt.wr_cur  = s_r.wr_start; // [RQ25]
         s_nxt.rd_done = 1'b0;
         s_nxt.wr_done = 1'b0;
      end

      // Level: live; edge: sticky
      if (edge_mode) begin
         s_nxt.status[3:0] = (s_r.status[3:0] & ~clr[3:0]) | evt[3:0]; // [RQ13]
      end else begin
         s_nxt.status[3:0] = lvl[3:0]; // [RQ12]
      end
      // Set beats clear: no lost abort
      s_nxt.status[5:4] = (s_r.status[5:4] & ~clr[5:4]) | evt[5:4]; // [RQ9]

      s_nxt.irq = |(s_r.status[3:0] & s_r.mask) || |s_r.status[5:4]; // [RQ8] [RQ24]

      // Flagged words go to the codec
      if (wrf_pop) begin
         s_nxt.tx_valid = 1'b0;
         if (wrf_valid) begin
            if (indirect && wrf_data[0]) begin // [RQ18]
               s_nxt.codec.wr   = 1'b1;
               s_nxt.codec.addr = wrf_data[15:8];
               s_nxt.codec.data = {1'b0, wrf_data[7:1]};
            end else begin
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_data  = indirect ? {wrf_data[15:1], 1'b0} : wrf_data; // [RQ19]
            end
         end
      end
      s_nxt.rx_ready = rdf_in_ready;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{ctrl: pdm_pkg::CTRL_RESET, status: pdm_pkg::STATUS_RESET, mask: pdm_pkg::MASK_RESET,
                  rd_start: pdm_pkg::ADDR_RESET, rd_end: pdm_pkg::ADDR_RESET, rd_irq: pdm_pkg::ADDR_RESET,
                  rd_cur: pdm_pkg::ADDR_RESET, wr_start: pdm_pkg::ADDR_RESET, wr_end: pdm_pkg::ADDR_RESET,
                  wr_irq: pdm_pkg::ADDR_RESET, wr_cur: pdm_pkg::ADDR_RESET, rd_done: 1'b0, wr_done: 1'b0,
                  prev_en: 1'b0, last_wr: 1'b0, mst: pdm_pkg::MS_IDLE, mreq: '0, rsp: '0, codec: '0,
                  tx_valid: 1'b0, tx_data: 16'h0, rx_ready: 1'b0, irq: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// [pdm_dma_chk.sv]
// Checker: DMA engine port properties
`timescale 1ns/1ps
module pdm_dma_chk (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire pdm_pkg::pdm_tgt_req_t tgt_req,
   input wire pdm_pkg::pdm_tgt_rsp_t tgt_rsp,
   input wire pdm_pkg::pdm_mst_req_t mst_req,
   input wire logic                  mst_ack,
   input wire logic                  mst_mabort,
   input wire logic                  mst_tabort,
   input wire logic                  irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic v = tgt_req.valid;
   wire logic [3:0] c = tgt_req.cmd;
   wire logic m = tgt_req.bar_mem && tgt_req.addr[1:0] == 2'h0;
   wire logic e = mst_ack || mst_mabort || mst_tabort;
   wire logic q = mst_req.req;
   property p_done; v |=> tgt_rsp.done; endproperty
   a_done: assert property (p_done) else $error("no answer");
   property p_nosup; v && c inside {4'h0, 4'h1, 4'hd} |=> !tgt_rsp.claim; endproperty
   a_nosup: assert property (p_nosup) else $error("bad claim");
   property p_cfg; v && c[3:1] == 3'h5 |=> tgt_rsp.claim; endproperty
   a_cfg: assert property (p_cfg) else $error("cfg refused");
   property p_mem; v && m && c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf} |=> tgt_rsp.claim; endproperty
   a_mem: assert property (p_mem) else $error("mem refused");
   property p_hold; q && !e |=> q && $stable(mst_req.addr) && $stable(mst_req.wdata); endproperty
   a_hold: assert property (p_hold) else $error("req moved");
   property p_ackdrop; q && mst_ack |=> !q; endproperty
   a_ackdrop: assert property (p_ackdrop) else $error("req held");
   property p_abort; q && mst_mabort |=> !q [*2]; endproperty
   a_abort: assert property (p_abort) else $error("no halt");
   property p_irq; q && mst_mabort |-> ##[1:3] irq; endproperty
   a_irq: assert property (p_irq) else $error("no irq");
   property p_align; q |-> mst_req.addr[1:0] == 2'h0 && (!mst_req.write || mst_req.wdata[31:16] == 16'h0);
   endproperty
   a_align: assert property (p_align) else $error("bad word");
   c_ab: cover property (q && mst_mabort);
   c_wr: cover property (q && mst_req.write && mst_ack);
   c_rd: cover property (q && !mst_req.write && mst_ack);
endmodule
bind pdm_dma pdm_dma_chk i_pdm_dma_chk (.core_clk(core_clk), .rst_n(rst_n), .tgt_req(tgt_req), .tgt_rsp(tgt_rsp),
   .mst_req(mst_req), .mst_ack(mst_ack), .mst_mabort(mst_mabort), .mst_tabort(mst_tabort), .irq(irq));

// [pdm_dma_tb_top.sv]
// Testbench for the DMA engine
`timescale 1ns/1ps
module pdm_dma_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   pdm_pkg::pdm_tgt_req_t tgt_req = '0;
   pdm_pkg::pdm_tgt_rsp_t tgt_rsp;
   pdm_pkg::pdm_mst_req_t mst_req;
   pdm_pkg::pdm_codec_t   codec, cw;
   logic mst_ack, mst_mabort, mst_tabort, rx_ready, tx_valid, irq, cl;
   logic rx_valid = 1'b0, slow = 1'b0, abort_req = 1'b0;
   logic [15:0] rx_data = 16'h0, tx_data, tx_first;
   logic [31:0] mst_rdata, last_wdata, rd;
   int n_mismatch = 0, tests_run = 0, n_tx = 0, cyc = 0, base;
   initial forever #5 core_clk = ~core_clk;
   pdm_dma i_pdm_dma (.core_clk(core_clk), .rst_n(rst_n), .tgt_req(tgt_req), .tgt_rsp(tgt_rsp), .mst_req(mst_req),
      .mst_ack(mst_ack), .mst_rdata(mst_rdata), .mst_mabort(mst_mabort), .mst_tabort(mst_tabort), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(1'b1), .tx_data(tx_data),
      .codec(codec), .codec_rdata(8'h5a), .irq(irq));
   pdm_mem_model i_pdm_mem_model (.core_clk(core_clk), .rst_n(rst_n), .mst_req(mst_req), .slow(slow),
      .abort_req(abort_req), .mst_ack(mst_ack), .mst_rdata(mst_rdata), .mst_mabort(mst_mabort),
      .mst_tabort(mst_tabort), .last_wdata(last_wdata));
   task complete_run;
      $display("Mismatches %0d of %0d comparisons", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (tx_valid && n_tx == 0) tx_first = tx_data;
      if (codec.wr) cw = codec;
      n_tx = n_tx + tx_valid + codec.wr;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic acc(input logic [3:0] c, input logic [11:0] a, input logic [31:0] wd);
      @(negedge core_clk);
      tgt_req <= '{1'b1, c, c[3:1] != 3'h1, c[3:1] == 3'h1, a, wd};
      @(negedge core_clk);
      tgt_req.valid <= 1'b0;
      rd = tgt_rsp.rdata;
      cl = tgt_rsp.claim;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      tests_run++;
      if (s !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, e, input string nm);
      acc(4'h6, a, 32'h0);
      chk(nm, e, rd & m);
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      rdc(12'h000, '1, 32'h0, "ctrl");
      rdc(12'h014, '1, 32'h0, "rd cur");
      for (int c = 0; c < 16; c++) begin
         acc(c[3:0], 12'h028, 32'h0);
         chk("claim", 32'(16'hdccc >> c) & 32'h1, {31'h0, cl});
      end
      acc(4'h3, 12'h028, 32'h2);
      rdc(12'h028, 32'hf, 32'h2, "mask");
      acc(4'hf, 12'h008, 32'h100);
      acc(4'h7, 12'h00c, 32'h108);
      acc(4'h7, 12'h010, 32'h104);
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_data = 16'h1234;
      @(negedge core_clk);
      rx_data = 16'h5678;
      @(negedge core_clk);
      rx_valid = 1'b0;
      acc(4'h7, 12'h000, 32'h1c0);
      for (int i = 0; i < 200 && last_wdata !== 32'h5678; i++) @(negedge core_clk);
      rdc(12'h014, '1, 32'h100, "rd wrap");
      chk("irq", 32'h1, {31'h0, irq});
      rdc(12'h004, 32'h2, 32'h2, "irq addr");
      rdc(12'h004, 32'h2, 32'h0, "rd clear");
      acc(4'h7, 12'h000, 32'h0);
      slow = 1'b1;
      acc(4'h7, 12'h018, 32'h200);
      acc(4'h7, 12'h01c, 32'h208);
      acc(4'h7, 12'h028, 32'h4);
      acc(4'h7, 12'h000, 32'h900);
      for (int i = 0; i < 300 && n_tx < 2; i++) @(negedge core_clk);
      chk("tx", 32'h200, {16'h0, tx_first});
      chk("codec", 32'h10202, {15'h0, cw});
      rdc(12'h024, '1, 32'h208, "wr halt");
      rdc(12'h004, 32'h4, 32'h4, "eob");
      rdc(12'h004, 32'h4, 32'h4, "eob held");
      acc(4'h7, 12'h000, 32'hb00);
      for (int i = 0; i < 300 && n_tx < 4; i++) @(negedge core_clk);
      chk("restart", 32'h4, n_tx);
      abort_req = 1'b1;
      acc(4'h7, 12'h000, 32'hb00);
      for (int i = 0; i < 30 && !rd[4]; i++) acc(4'h6, 12'h004, 32'h0);
      chk("abort", 32'h10, rd & 32'h30);
      rdc(12'h000, 32'h100, 32'h0, "en off");
      abort_req = 1'b0;
      base = n_tx;
      acc(4'h7, 12'h000, 32'h900);
      for (int i = 0; i < 300 && n_tx < base + 2; i++) @(negedge core_clk);
      chk("resume", 32'(base + 2), n_tx);
      complete_run();
   end
endmodule

// [pdm_fifo.sv]
// Sample FIFO, valid/ready both sides
`timescale 1ns/1ps
module pdm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          full;
      logic          empty;
   } pdm_fifo_st_t;

   pdm_fifo_st_t     s_r;
   pdm_fifo_st_t     s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   assign push      = in_valid && !s_r.full;
   assign pop       = out_ready && !s_r.empty;
   assign in_ready  = !s_r.full;
   assign out_valid = !s_r.empty;
   assign out_data  = mem[s_r.rp];

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
      end
      s_nxt.cnt   = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      s_nxt.full  = (s_nxt.cnt == (AW+1)'(DEPTH));
      s_nxt.empty = (s_nxt.cnt == '0);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   // No reset; pointers define validity
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[s_r.wp] <= in_data;
      end
   end
endmodule

// [pdm_mem_model.sv]
// Partner: host memory model
`timescale 1ns/1ps
module pdm_mem_model (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire pdm_pkg::pdm_mst_req_t mst_req,
   input  wire logic                  slow,
   input  wire logic                  abort_req,
   output      logic                  mst_ack,
   output      logic [31:0]           mst_rdata,
   output      logic                  mst_mabort,
   output      logic                  mst_tabort,
   output      logic [31:0]           last_wdata
);
   logic [1:0] wait_r;
   // Bit 0 copies address bit 2 so some fetched words are flagged
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {mst_ack, mst_mabort, mst_tabort, wait_r, mst_rdata, last_wdata} <= '0;
      end else begin
         {mst_ack, mst_mabort, mst_tabort} <= 3'h0;
         mst_rdata <= ~mst_rdata; // Idle bus inverts each cycle; stale data returns every other cycle
         if (mst_req.req && !mst_ack && !mst_mabort) begin
            wait_r <= wait_r + 2'h1;
            if (wait_r == {slow, slow}) begin
               wait_r <= 2'h0;
               mst_ack <= !abort_req;
               mst_mabort <= abort_req;
               mst_rdata <= {16'h0, mst_req.addr[15:1], mst_req.addr[2]};
               if (mst_req.write) last_wdata <= mst_req.wdata;
            end
         end
      end
   end
endmodule

// [pdm_pkg.sv]
// Package: PCI DMA engine map, codes and types
package pdm_pkg;
   // Register offsets
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   localparam logic [11:0] OFF_STATUS   = 12'h004;
   localparam logic [11:0] OFF_RD_START = 12'h008;
   localparam logic [11:0] OFF_RD_END   = 12'h00c;
   localparam logic [11:0] OFF_RD_IRQ   = 12'h010;
   localparam logic [11:0] OFF_RD_CUR   = 12'h014;
   localparam logic [11:0] OFF_WR_START = 12'h018;
   localparam logic [11:0] OFF_WR_END   = 12'h01c;
   localparam logic [11:0] OFF_WR_IRQ   = 12'h020;
   localparam logic [11:0] OFF_WR_CUR   = 12'h024;
   localparam logic [11:0] OFF_MASK     = 12'h028;
   // Offset bit selecting codec registers
   localparam int          CODEC_SEL_BIT = 10;

   // Control register fields
   localparam int CTL_RST      = 1;
   localparam int CTL_IRQ_EDGE = 6;
   localparam int CTL_MULTI    = 7;
   localparam int CTL_EN       = 8;
   localparam int CTL_RESTART  = 9;
   localparam int CTL_DM_LO    = 11;
   localparam int CTL_DM_HI    = 12;
   localparam logic [1:0]  DM_INDIRECT   = 2'h1;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK  = 32'h0000_19c2;

   // Status register fields
   localparam int ST_RD_EOB  = 0;
   localparam int ST_RD_IA   = 1;
   localparam int ST_WR_EOB  = 2;
   localparam int ST_WR_IA   = 3;
   localparam int ST_MABORT  = 4;
   localparam int ST_TABORT  = 5;
   localparam logic [5:0] STATUS_RESET = 6'h00;
   localparam logic [3:0] MASK_RESET   = 4'h0;
   localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
   localparam logic [31:0] DWORD_STEP  = 32'h0000_0004;

   // Sample FIFOs
   localparam int SAMPLE_W   = 16;
   localparam int FIFO_DEPTH = 8;

   // PCI bus commands
   localparam logic [3:0] CMD_INTA   = 4'h0;
   localparam logic [3:0] CMD_SPEC   = 4'h1;
   localparam logic [3:0] CMD_IO_RD  = 4'h2;
   localparam logic [3:0] CMD_IO_WR  = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MRM    = 4'hc;
   localparam logic [3:0] CMD_DAC    = 4'hd;
   localparam logic [3:0] CMD_MRL    = 4'he;
   localparam logic [3:0] CMD_MWI    = 4'hf;

   typedef enum logic [1:0] {MS_IDLE, MS_BUSY, MS_HALT} pdm_mst_state_t;

   typedef struct packed {
      logic        claim;
      logic        is_read;
      logic        is_write;
      logic        is_cfg;
   } pdm_dec_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  cmd;
      logic        bar_mem;
      logic        bar_io;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pdm_tgt_req_t;

   typedef struct packed {
      logic        done;
      logic        claim;
      logic [31:0] rdata;
   } pdm_tgt_rsp_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pdm_mst_req_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } pdm_codec_t;
endpackage
